/* File: design/spc_params.svh */
/*
   constants of the sensor setup and calibration register block: register
   offsets, field positions, reset values and the host's own register map.
   assumes inclusion by bare name from every design file that needs a number.
*/
// Functional notes
// - setup field resets to 10, 10 starts setup
// - host never writes 00, 01 or 11
// - host writes setup bits 7..2 as zero
// - host programs setup before expecting conversions
// - pressure linearity words 22h-24h, zero before load
// - temperature correction words at 26h-2Ch
// - temperature sensor linearity words 2Eh-32h
// - extension upper byte widens pressure offset
// - extension lower byte widens sensor offset
// - coefficients returned unsigned, no sign handling
// - host clears read-disable bit before coefficient reads
// - read-disable bit resets to one
// - returned bytes shift out MSB first
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH

`define SPC_ADDR_OTP_CTRL   8'h08
`define SPC_ADDR_SETUP      8'h0A
`define SPC_ADDR_PR2        8'h22
`define SPC_ADDR_PR3        8'h24
`define SPC_ADDR_TEMP2      8'h26
`define SPC_ADDR_TEMP3      8'h28
`define SPC_ADDR_TEMP22     8'h2A
`define SPC_ADDR_TEMP23     8'h2C
`define SPC_ADDR_PTAT2      8'h2E
`define SPC_ADDR_PTAT3      8'h32
`define SPC_ADDR_CEX        8'h34
`define SPC_ADDR_OTP_FIRST  8'h22
`define SPC_ADDR_OTP_LAST   8'h34

`define SPC_NUM_COEF        9
`define SPC_COEF_W          16
`define SPC_IDX_PR3         1
`define SPC_IDX_PTAT3       7
`define SPC_IDX_CEX         8

`define SPC_SETUP_RST       2'h2
`define SPC_SETUP_GO        2'h2
`define SPC_SETUP_RSV_MSB   7
`define SPC_SETUP_RSV_LSB   2
`define SPC_OTP_CTRL_RST    8'h65
`define SPC_OTP_DIS_BIT     6

`define SPC_H_CTRL          4'h0
`define SPC_H_STATUS        4'h4
`define SPC_H_RDATA         4'h8
`define SPC_H_WDATA_LSB     8
`define SPC_H_WRITE_BIT     16
`define SPC_H_START_BIT     17
`define SPC_H_ST_BUSY       0
`define SPC_H_ST_DONE       1
`define SPC_H_ST_ERR        2
`define SPC_H_ST_SETUP      3
`define SPC_H_ST_OTP_EN     4

`endif

/* File: design/spc_pkg.sv */
/*
   types shared by both ends of the sensor register link.
   assumes spc_params.svh supplies the widths.
*/
`include "spc_params.svh"

package spc_pkg;
   typedef logic [`SPC_COEF_W-1:0] spc_coef_type;
   typedef spc_coef_type [`SPC_NUM_COEF-1:0] spc_coef_set_type;
   typedef logic [7:0] spc_addr_type;
   typedef enum logic [0:0]
   {
      SPC_H_IDLE = 1'b0,
      SPC_H_WAIT = 1'b1
   } spc_host_state_type;
endpackage : spc_pkg

/* File: design/spc_link_if.sv */
/*
   link between the register host and the sensor register block.
   assumes one shared clock; commands are one-cycle pulses, read data
   comes back one bit per cycle.
*/
interface spc_link_if;
   logic       cmd_valid;
   logic       cmd_write;
   logic [7:0] cmd_addr;
   logic [7:0] cmd_wdata;
   logic       busy;
   logic       rd_bit;
   logic       rd_valid;
   logic       rd_last;

   modport host
   (
      output cmd_valid,
      output cmd_write,
      output cmd_addr,
      output cmd_wdata,
      input  busy,
      input  rd_bit,
      input  rd_valid,
      input  rd_last
   );

   modport device
   (
      input  cmd_valid,
      input  cmd_write,
      input  cmd_addr,
      input  cmd_wdata,
      output busy,
      output rd_bit,
      output rd_valid,
      output rd_last
   );
endinterface : spc_link_if

/* File: design/spc_shift_out.sv */
/*
   serialiser for read answers: a left-aligned word goes out one bit per
   cycle, highest bit first.
   assumes load only while not busy.
*/
`include "spc_params.svh"

module spc_shift_out
#(
   parameter int WIDTH = `SPC_COEF_W
)
(
   input  wire logic             clk_sys_in,
   input  wire logic             rst_in,
   input  wire logic             load_in,
   input  wire logic [WIDTH-1:0] data_in,
   input  wire logic [4:0]       nbits_in,
   output logic                  bit_out,
   output logic                  valid_out,
   output logic                  last_out,
   output logic                  busy_out
);
   import spc_pkg::*;

   generate
      if (WIDTH < 8 || WIDTH > 16)
      begin : g_bad_width
         $error("spc_shift_out: WIDTH must lie between 8 and 16");
      end
   endgenerate

   logic [WIDTH-1:0] sh_reg;
   logic [4:0]       cnt_reg;
   wire              shifting = (cnt_reg != 5'h0);

   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         sh_reg    <= '0;
         cnt_reg   <= 5'h0;
         bit_out   <= 1'b0;
         valid_out <= 1'b0;
         last_out  <= 1'b0;
         busy_out  <= 1'b0;
      end
      else if (load_in)
      begin
         sh_reg    <= data_in;
         cnt_reg   <= nbits_in;
         valid_out <= 1'b0;
         last_out  <= 1'b0;
         busy_out  <= 1'b1;
      end
      else
      begin
         // msb leaves first
         bit_out   <= sh_reg[WIDTH-1];
         sh_reg    <= {sh_reg[WIDTH-2:0], 1'b0};
         valid_out <= shifting;
         last_out  <= (cnt_reg == 5'h1);
         cnt_reg   <= shifting ? cnt_reg - 5'h1 : 5'h0;
         busy_out  <= (cnt_reg > 5'h1);
      end
   end
endmodule : spc_shift_out

/* File: design/spc_device.sv */
/*
   sensor end: setup register, read-control register and the read-only
   calibration words, answered over the link.
   assumes calibration words arrive on a one-cycle load strobe and a host
   that keeps its own obligations on setup codes and read enabling.
*/
// The implementer's own choice: strobed register access.
`include "spc_params.svh"

module spc_device
(
   input  wire logic                      clk_sys_in,
   input  wire logic                      rst_in,
   spc_link_if.device                     link,
   input  wire logic                      otp_load_in,
   input  wire spc_pkg::spc_coef_set_type otp_coef_in,
   output logic [1:0]                     setup_code_out,
   output logic                           adc_setup_req_out,
   output logic                           adc_setup_launch_out,
   output logic                           otp_read_enabled_out,
   output logic                           otp_loaded_out,
   output logic [23:0]                    pressure_offset_coeff_out,
   output logic [23:0]                    temp_sensor_offset_coeff_out
);
   import spc_pkg::*;

   localparam spc_addr_type COEF_ADDR [`SPC_NUM_COEF] =
   '{
      `SPC_ADDR_PR2,
      `SPC_ADDR_PR3,
      `SPC_ADDR_TEMP2,
      `SPC_ADDR_TEMP3,
      `SPC_ADDR_TEMP22,
      `SPC_ADDR_TEMP23,
      `SPC_ADDR_PTAT2,
      `SPC_ADDR_PTAT3,
      `SPC_ADDR_CEX
   };

   logic [1:0]       setup_reg;
   logic [1:0]       setup_next;
   logic             otp_dis_reg;
   logic             otp_dis_next;
   logic             launch_next;
   logic             loaded_reg;
   spc_coef_set_type coef_reg;

   // command decode
   wire shift_busy;
   wire take      = link.cmd_valid & ~shift_busy;
   wire take_wr   = take & link.cmd_write;
   wire take_rd   = take & ~link.cmd_write;
   wire wr_setup  = take_wr & (link.cmd_addr == `SPC_ADDR_SETUP);
   wire wr_otpctl = take_wr & (link.cmd_addr == `SPC_ADDR_OTP_CTRL);

   // calibration word select
   logic [`SPC_NUM_COEF-1:0] coef_hit;
   spc_coef_type             coef_term [`SPC_NUM_COEF];
   spc_coef_type             coef_or   [`SPC_NUM_COEF+1];

   assign coef_or[0] = '0;

   genvar gi;
   generate
      for (gi = 0; gi < `SPC_NUM_COEF; gi++)
      begin : g_coef
         assign coef_hit[gi]    = (link.cmd_addr == COEF_ADDR[gi]);
         assign coef_term[gi]   = coef_hit[gi] ? coef_reg[gi] : '0;
         assign coef_or[gi + 1] = coef_or[gi] | coef_term[gi];
      end
   endgenerate

   wire is_coef = |coef_hit;

   // words pass out as stored bits, no sign extension anywhere
   wire spc_coef_type coef_word = otp_dis_reg ? '0 : coef_or[`SPC_NUM_COEF];

   // byte registers: reserved bits read as zero in setup, fixed pattern in control
   wire [7:0] setup_byte  = {6'h00, setup_reg};
   wire [7:0] otpctl_byte = otp_dis_reg ?
                            (`SPC_OTP_CTRL_RST) :
                            (`SPC_OTP_CTRL_RST & ~(8'h01 << `SPC_OTP_DIS_BIT));

   wire [7:0] byte_word =
      (link.cmd_addr == `SPC_ADDR_SETUP)    ? setup_byte  :
      (link.cmd_addr == `SPC_ADDR_OTP_CTRL) ? otpctl_byte :
                                              8'h00;

   // left-align so both lengths leave msb first
   wire spc_coef_type shift_word = is_coef ? coef_word : {byte_word, 8'h00};
   wire [4:0]         shift_len  = is_coef ? 5'h10 : 5'h08;

   spc_shift_out
   #(
      .WIDTH (`SPC_COEF_W)
   )
   u_shift
   (
      .clk_sys_in (clk_sys_in),
      .rst_in     (rst_in),
      .load_in    (take_rd),
      .data_in    (shift_word),
      .nbits_in   (shift_len),
      .bit_out    (link.rd_bit),
      .valid_out  (link.rd_valid),
      .last_out   (link.rd_last),
      .busy_out   (shift_busy)
   );

   assign link.busy = shift_busy;

   // only the two low bits hold state; the host keeps reserved bits zero
   assign setup_next   = wr_setup ? link.cmd_wdata[1:0] : setup_reg;
   assign launch_next  = wr_setup & (link.cmd_wdata[1:0] == `SPC_SETUP_GO);
   assign otp_dis_next = wr_otpctl ? link.cmd_wdata[`SPC_OTP_DIS_BIT] : otp_dis_reg;

   // offsets widen to 24 bits; the extension word only ever prefixes, never adds
   wire [23:0] pr_off_next    = {coef_reg[`SPC_IDX_CEX][15:8], coef_reg[`SPC_IDX_PR3]};
   wire [23:0] proportional_temp_sensor_off_next  = {coef_reg[`SPC_IDX_CEX][7:0], coef_reg[`SPC_IDX_PTAT3]};
   wire        setup_req_next = (setup_reg == `SPC_SETUP_GO);

   // setup field register
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
         setup_reg <= `SPC_SETUP_RST;
      else
         setup_reg <= setup_next;
   end

   // read-disable comes up set, so a cold host never sees half-loaded words
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
         otp_dis_reg <= 1'b1;
      else
         otp_dis_reg <= otp_dis_next;
   end

   // coefficients stay zero until the store presents them
   // limitation: one strobe fills every word, no partial update
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
         coef_reg <= '0;
      else if (otp_load_in)
         coef_reg <= otp_coef_in;
   end

   // loaded level stays up until the next reset
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
         loaded_reg <= 1'b0;
      else if (otp_load_in)
         loaded_reg <= 1'b1;
   end

   // user side outputs, all registered; one cycle of lag buys clean timing
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         setup_code_out       <= `SPC_SETUP_RST;
         adc_setup_req_out    <= 1'b0;
         adc_setup_launch_out <= 1'b0;
      end
      else
      begin
         setup_code_out       <= setup_reg;
         adc_setup_req_out    <= setup_req_next;
         adc_setup_launch_out <= launch_next;
      end
   end

   // read-enable mirrors the disable bit, inverted
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         otp_read_enabled_out <= 1'b0;
         otp_loaded_out       <= 1'b0;
      end
      else
      begin
         otp_read_enabled_out <= ~otp_dis_reg;
         otp_loaded_out       <= loaded_reg;
      end
   end

   // offsets follow the store even while link reads are disabled
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         pressure_offset_coeff_out    <= 24'h00_0000;
         temp_sensor_offset_coeff_out <= 24'h00_0000;
      end
      else
      begin
         pressure_offset_coeff_out    <= pr_off_next;
         temp_sensor_offset_coeff_out <= proportional_temp_sensor_off_next;
      end
   end
endmodule : spc_device

/* File: design/spc_host.sv */
/*
   host end: takes orders through its own small register port, issues
   link commands and reassembles serial read answers.
   assumes a single-cycle strobe master with read data one cycle later.
*/
`include "spc_params.svh"

module spc_host
(
   input  wire logic        clk_sys_in,
   input  wire logic        rst_in,
   spc_link_if.host         link,
   input  wire logic [3:0]  reg_addr_in,
   input  wire logic [31:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic [31:0]      reg_rdata_out
);
   import spc_pkg::*;

   spc_host_state_type state_reg;
   logic [15:0]        shift_reg;
   logic [15:0]        rdata_reg;
   logic               done_reg;
   logic               err_reg;
   logic               setup_done_reg;
   logic               otp_dis_shadow_reg;

   wire [7:0] o_addr  = reg_wdata_in[7:0];
   wire [7:0] o_data  = reg_wdata_in[`SPC_H_WDATA_LSB+7:`SPC_H_WDATA_LSB];
   wire       o_write = reg_wdata_in[`SPC_H_WRITE_BIT];
   wire       busy    = (state_reg != SPC_H_IDLE) | link.busy;
   wire       start   = reg_wr_in & (reg_addr_in == `SPC_H_CTRL)
                        & reg_wdata_in[`SPC_H_START_BIT] & ~busy;

   // refuse orders the sensor must never see
   wire bad_setup = o_write & (o_addr == `SPC_ADDR_SETUP)
                    & ((o_data[1:0] != `SPC_SETUP_GO)
                    | (o_data[`SPC_SETUP_RSV_MSB:`SPC_SETUP_RSV_LSB] != 6'h00));
   wire is_otp    = (o_addr >= `SPC_ADDR_OTP_FIRST) & (o_addr <= `SPC_ADDR_OTP_LAST);
   wire bad_otp   = ~o_write & is_otp & otp_dis_shadow_reg;
   wire issue     = start & ~bad_setup & ~bad_otp;
   wire refuse    = start & (bad_setup | bad_otp);
   wire rd_end    = (state_reg == SPC_H_WAIT) & link.rd_valid & link.rd_last;
   wire wr_end    = issue & o_write;
   wire clr_st    = reg_wr_in & (reg_addr_in == `SPC_H_STATUS);

   wire [15:0] shift_next = {shift_reg[14:0], link.rd_bit};

   wire [31:0] status_word = {27'h000_0000, ~otp_dis_shadow_reg, setup_done_reg,
                              err_reg, done_reg, busy};
   wire [31:0] rd_mux =
      (reg_addr_in == `SPC_H_STATUS) ? status_word :
      (reg_addr_in == `SPC_H_RDATA)  ? {16'h0000, rdata_reg} :
                                       32'h0000_0000;

   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         state_reg      <= SPC_H_IDLE;
         link.cmd_valid <= 1'b0;
         link.cmd_write <= 1'b0;
         link.cmd_addr  <= 8'h00;
         link.cmd_wdata <= 8'h00;
      end
      else
      begin
         link.cmd_valid <= issue;
         if (issue)
         begin
            link.cmd_write <= o_write;
            link.cmd_addr  <= o_addr;
            link.cmd_wdata <= o_data;
         end
         case (state_reg)
            SPC_H_IDLE: state_reg <= (issue & ~o_write) ? SPC_H_WAIT : SPC_H_IDLE;
            SPC_H_WAIT: state_reg <= rd_end ? SPC_H_IDLE : SPC_H_WAIT;
            default:    state_reg <= SPC_H_IDLE;
         endcase
      end
   end

   // flags: a hardware set wins over a software clear
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         shift_reg          <= 16'h0000;
         rdata_reg          <= 16'h0000;
         done_reg           <= 1'b0;
         err_reg            <= 1'b0;
         setup_done_reg     <= 1'b0;
         otp_dis_shadow_reg <= 1'b1;
         reg_rdata_out      <= 32'h0000_0000;
      end
      else
      begin
         if (link.rd_valid)
            shift_reg <= shift_next;
         if (rd_end)
            rdata_reg <= shift_next;
         done_reg <= (rd_end | wr_end)
                     | (done_reg & ~(clr_st & reg_wdata_in[`SPC_H_ST_DONE]));
         err_reg  <= refuse | (err_reg & ~(clr_st & reg_wdata_in[`SPC_H_ST_ERR]));
         if (wr_end & (o_addr == `SPC_ADDR_SETUP))
            setup_done_reg <= 1'b1;
         if (wr_end & (o_addr == `SPC_ADDR_OTP_CTRL))
            otp_dis_shadow_reg <= o_data[`SPC_OTP_DIS_BIT];
         reg_rdata_out <= reg_rd_in ? rd_mux : 32'h0000_0000;
      end
   end
endmodule : spc_host

/* File: tb/spc_link_assertions.sv */
/*
   link checker: concurrent properties on the wire between host and device.
   assumes one clock and a synchronous active-high reset.
*/
module spc_link_assertions
(
   input wire logic       clk_sys_in,
   input wire logic       rst_in,
   input wire logic       cmd_valid,
   input wire logic       cmd_write,
   input wire logic [7:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   input wire logic       busy,
   input wire logic       rd_bit,
   input wire logic       rd_valid,
   input wire logic       rd_last
);
   timeunit 1ns;
   timeprecision 1ps;

   logic take;
   logic rd_take;
   logic is_coef;
   logic otp_dis_reg;

   default clocking @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);

   assign take    = cmd_valid && !busy;
   assign rd_take = take && !cmd_write;
   // 30h is a hole in the word range, answered as one byte
   assign is_coef = cmd_addr inside {8'h22, 8'h24, 8'h26, 8'h28, 8'h2A, 8'h2C, 8'h2E,
                                     8'h32, 8'h34};

   // shadow of the read-disable bit; no write is taken while busy
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
         otp_dis_reg <= 1'b1;
      else if (take && cmd_write && cmd_addr == 8'h08)
         otp_dis_reg <= cmd_wdata[6];
   end

   word_length_a:
      assert property (rd_take && is_coef |-> ##2 (rd_valid && !rd_last)[*8]
         ##1 (rd_valid && !rd_last)[*7] ##1 (rd_valid && rd_last))
      else $error("coefficient answer is not sixteen bits");
   byte_length_a:
      assert property (rd_take && !is_coef |-> ##2 (rd_valid && !rd_last)[*7]
         ##1 (rd_valid && rd_last))
      else $error("byte answer is not eight bits");
   setup_value_a:
      assert property (rd_take && cmd_addr == 8'h0A |-> ##2 (!rd_bit)[*6] ##1 rd_bit
         ##1 !rd_bit)
      else $error("setup register does not read 02h");
   otp_value_a:
      assert property (rd_take && cmd_addr == 8'h08 |-> ##2 !rd_bit ##1 rd_bit == otp_dis_reg
         ##1 rd_bit ##1 (!rd_bit)[*2] ##1 rd_bit ##1 !rd_bit ##1 rd_bit)
      else $error("read control register value wrong");
   read_busy_a:
      assert property (rd_take |=> busy)
      else $error("read taken without busy");
   write_quiet_a:
      assert property (take && cmd_write |=> !busy ##1 !rd_valid)
      else $error("write produced an answer");
   bit_busy_a:
      assert property (rd_valid && !rd_last |-> busy)
      else $error("answer bit outside busy");
   valid_source_a:
      assert property (rd_valid |-> $past(busy))
      else $error("answer bit without preceding busy");
   answer_gapless_a:
      assert property (rd_valid && !rd_last |=> rd_valid)
      else $error("gap inside an answer");

   cover property (rd_take && is_coef && !otp_dis_reg);
   cover property (take && cmd_write && cmd_addr == 8'h0A);
   cover property (rd_take && cmd_addr == 8'h08 && !otp_dis_reg);
endmodule : spc_link_assertions

/* File: tb/test_sensor_setup_calib_regs.sv */
/*
   self-checking bench: host and device joined by the link, driven through
   the host register port.
   assumes the design files and spc_params.svh are compiled first.
*/
`include "spc_params.svh"

module test_sensor_setup_calib_regs;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {logic [7:0] addr; logic [15:0] val;} spc_row_type;
   // high bits set on purpose: values must come back unsigned
   spc_row_type rows [9] = '{24'h22_8A51, 24'h24_C3B2, 24'h26_1234, 24'h28_FEDC,
      24'h2A_0F0F, 24'h2C_7001, 24'h2E_9876, 24'h32_5AA5, 24'h34_E14B};

   logic                      clk_sys_in = 1'b0;
   logic                      rst_in     = 1'b1;
   logic [3:0]                reg_addr   = 4'h0;
   logic [31:0]               reg_wdata  = 32'h0000_0000;
   logic                      reg_wr     = 1'b0;
   logic                      reg_rd     = 1'b0;
   logic [31:0]               reg_rdata;
   logic                      otp_load   = 1'b0;
   spc_pkg::spc_coef_set_type otp_coef   = '0;
   logic [1:0]                setup_code;
   logic                      setup_req;
   logic                      setup_launch;
   logic                      otp_en;
   logic                      otp_loaded;
   logic [23:0]               pr_off;
   logic [23:0]               proportional_temp_sensor_off;
   int                        errors      = 0;
   int                        checks_done = 0;
   int                        launches    = 0;
   logic [7:0]                bad [4]     = '{8'h00, 8'h01, 8'h03, 8'h06};

   always #4 clk_sys_in = ~clk_sys_in;

   always @(posedge clk_sys_in)
      if (setup_launch === 1'b1)
         launches <= launches + 1;

   spc_link_if link ();

   spc_device i_spc_device
   (
      .clk_sys_in                   (clk_sys_in),
      .rst_in                       (rst_in),
      .link                         (link),
      .otp_load_in                  (otp_load),
      .otp_coef_in                  (otp_coef),
      .setup_code_out               (setup_code),
      .adc_setup_req_out            (setup_req),
      .adc_setup_launch_out         (setup_launch),
      .otp_read_enabled_out         (otp_en),
      .otp_loaded_out               (otp_loaded),
      .pressure_offset_coeff_out    (pr_off),
      .temp_sensor_offset_coeff_out (proportional_temp_sensor_off)
   );

   spc_host i_spc_host
   (
      .clk_sys_in    (clk_sys_in),
      .rst_in        (rst_in),
      .link          (link),
      .reg_addr_in   (reg_addr),
      .reg_wdata_in  (reg_wdata),
      .reg_wr_in     (reg_wr),
      .reg_rd_in     (reg_rd),
      .reg_rdata_out (reg_rdata)
   );

   spc_link_assertions i_spc_link_assertions
   (
      .clk_sys_in (clk_sys_in),
      .rst_in     (rst_in),
      .cmd_valid  (link.cmd_valid),
      .cmd_write  (link.cmd_write),
      .cmd_addr   (link.cmd_addr),
      .cmd_wdata  (link.cmd_wdata),
      .busy       (link.busy),
      .rd_bit     (link.rd_bit),
      .rd_valid   (link.rd_valid),
      .rd_last    (link.rd_last)
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   // each access waits an edge first so a strobe is never lowered and raised at once
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr    <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys_in);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask : reg_read

   // a poll that runs out returns an unknown error flag, which no compare accepts
   task automatic link_op(input logic [7:0] a, input logic [7:0] wb, input logic wr,
                          output logic [31:0] d, output logic err);
      logic [31:0] s;
      int          n;
      s = '0;
      n = 0;
      reg_write(`SPC_H_CTRL, {14'h0000, 1'b1, wr, wb, a});
      while (s[`SPC_H_ST_DONE] !== 1'b1 && s[`SPC_H_ST_ERR] !== 1'b1 && n < 40)
      begin
         reg_read(`SPC_H_STATUS, s);
         n++;
      end
      err = (n < 40) ? s[`SPC_H_ST_ERR] : 1'bx;
      reg_read(`SPC_H_RDATA, d);
      reg_write(`SPC_H_STATUS, 32'h0000_0006);
   endtask : link_op

   task automatic conclude();
      if (errors == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude

   initial
   begin
      repeat (20000) @(posedge clk_sys_in);
      errors++;
      conclude();
   end

   initial
   begin
      logic [31:0] d;
      logic        e;
      repeat (3) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      #1;
      check(setup_code, 2'h2);
      check(setup_req, 1'h1);
      check(otp_en, 1'h0);
      check(otp_loaded, 1'h0);
      link_op(`SPC_ADDR_SETUP, 8'h00, 1'b0, d, e);
      check(d[7:0], 8'h02);
      link_op(`SPC_ADDR_OTP_CTRL, 8'h00, 1'b0, d, e);
      check(d[7:0], 8'h65);
      link_op(`SPC_ADDR_PR2, 8'h00, 1'b0, d, e);
      check(e, 1'h1);
      foreach (bad[i])
      begin
         link_op(`SPC_ADDR_SETUP, bad[i], 1'b1, d, e);
         check(e, 1'h1);
      end
      link_op(`SPC_ADDR_SETUP, 8'h02, 1'b1, d, e);
      check({e, setup_code}, 3'h2);
      check(launches, 32'h0000_0001);
      link_op(`SPC_ADDR_OTP_CTRL, 8'h25, 1'b1, d, e);
      link_op(`SPC_ADDR_OTP_CTRL, 8'h00, 1'b0, d, e);
      check({otp_en, d[7:0]}, 9'h125);
      for (int p = 0; p < 2; p++)
      begin
         if (p == 1)
         begin
            foreach (rows[i])
               otp_coef[i] <= rows[i].val;
            otp_load <= 1'b1;
            @(posedge clk_sys_in);
            otp_load <= 1'b0;
         end
         foreach (rows[i])
         begin
            link_op(rows[i].addr, 8'h00, 1'b0, d, e);
            check(d[15:0], p ? rows[i].val : 16'h0000);
         end
      end
      #1;
      check(otp_loaded, 1'h1);
      check(pr_off, {rows[8].val[15:8], rows[1].val});
      check(proportional_temp_sensor_off, {rows[8].val[7:0], rows[7].val});
      link_op(`SPC_ADDR_PR2, 8'hFF, 1'b1, d, e);
      link_op(`SPC_ADDR_PR2, 8'h00, 1'b0, d, e);
      check(d[15:0], rows[0].val);
      link_op(8'h30, 8'h00, 1'b0, d, e);
      check(d[7:0], 8'h00);
      @(posedge clk_sys_in);
      rst_in <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      #1;
      check({otp_en, setup_code}, 3'h2);
      check({otp_loaded, pr_off, proportional_temp_sensor_off}, 49'h0_0000_0000_0000);
      link_op(`SPC_ADDR_OTP_CTRL, 8'h00, 1'b0, d, e);
      check(d[7:0], 8'h65);
      conclude();
   end
endmodule : test_sensor_setup_calib_regs
